// file: core/sarseq_pkg.sv
// Constants, register map and state types of the converter sequencer control.
// Assumes a single 100 MHz clock domain and an APB master with 32-bit data.
package sarseq_pkg;

   // ===========================================================================
   // Register map (byte addresses on APB).
   localparam logic [7:0] SARSEQ_OFF_CTRL1  = 8'h00;
   localparam logic [7:0] SARSEQ_OFF_CTRL2  = 8'h04;
   localparam logic [7:0] SARSEQ_OFF_CTRL3  = 8'h08;
   localparam logic [7:0] SARSEQ_OFF_CHSEL  = 8'h0c;
   localparam logic [7:0] SARSEQ_OFF_PINCFG = 8'h10;
   localparam logic [7:0] SARSEQ_OFF_SCAN   = 8'h14;
   localparam logic [7:0] SARSEQ_OFF_STAT   = 8'h18;
   localparam logic [7:0] SARSEQ_OFF_MASK   = 8'h1c;
   localparam logic [7:0] SARSEQ_OFF_BUF    = 8'h40;

   // ===========================================================================
   // Field positions.
   localparam int SARSEQ_C1_ON     = 15;
   localparam int SARSEQ_C1_SSRC   = 5;
   localparam int SARSEQ_C1_SIMULTANEOUS_SAMPLE = 3;
   localparam int SARSEQ_C1_AUTO   = 2;
   localparam int SARSEQ_C1_SAMPLE_CONTROL_BIT   = 1;
   localparam int SARSEQ_C1_DONE   = 0;
   localparam int SARSEQ_C2_VREF   = 13;
   localparam int SARSEQ_C2_SMPI   = 2;
   localparam int SARSEQ_C2_BUFFER_SPLIT   = 1;
   localparam int SARSEQ_C2_ALTERNATE_INPUT_SELECT   = 0;
   localparam int SARSEQ_C3_SAMC   = 8;
   localparam int SARSEQ_ST_CONV   = 0;
   localparam int SARSEQ_ST_GROUP  = 1;

   // ===========================================================================
   // Reset values and timing.
   localparam logic [15:0] SARSEQ_RST_REG    = 16'h0000;
   localparam logic [15:0] SARSEQ_RST_PINCFG = 16'h0000;
   localparam logic [3:0]  SARSEQ_CONV_TAD   = 4'hc;
   localparam logic [2:0]  SARSEQ_TRG_SOFT   = 3'h0;
   localparam logic [2:0]  SARSEQ_TRG_TIMER  = 3'h2;
   localparam logic [2:0]  SARSEQ_TRG_EXT    = 3'h1;
   localparam logic [2:0]  SARSEQ_TRG_AUTO   = 3'h7;

   typedef enum logic [1:0] {
      SARSEQ_IDLE   = 2'b00,
      SARSEQ_SAMPLE = 2'b01,
      SARSEQ_CONV   = 2'b10
   } sarseq_state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } sarseq_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sarseq_apb_rsp_t;

   typedef struct packed {
      logic [3:0] chanSel;
      logic       refExt;
      logic       sampleHold;
      logic       convBusy;
      logic [9:0] approxTrial;
   } sarseq_analog_t;

   typedef struct packed {
      logic [15:0]      ctrl1;
      logic [15:0]      ctrl2;
      logic [15:0]      ctrl3;
      logic [15:0]      chsel;
      logic [15:0]      pincfg;
      logic [15:0]      scan;
      logic [1:0]       stat;
      logic [1:0]       mask;
      logic [159:0]     buffer;
      sarseq_state_t    state;
      logic [5:0]       divCnt;
      logic             tadTick;
      logic [4:0]       samCnt;
      logic [3:0]       bitCnt;
      logic [9:0]       sar;
      logic [3:0]       seqCnt;
      logic [3:0]       wrPtr;
      logic             half;
      logic             muxB;
      logic             trigPrev;
      sarseq_apb_rsp_t  rsp;
      sarseq_analog_t   ana;
      logic             irq;
      logic [15:0]      pinDigital;
   } sarseq_state_vec_t;

endpackage

// file: core/sarseq_top.sv
// Sequencer control of a 10-bit successive-approximation converter with APB registers.
// Assumes the analog front end answers each trial with a comparator level in the same cycle,
// and that timer and external triggers are synchronous single-cycle pulses.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
module sarseq_top (
   input  wire logic                         clk,
   input  wire logic                         srst,
   input  wire logic                         clkEn,
   input  wire sarseq_pkg::sarseq_apb_req_t  apbReq,
   output      sarseq_pkg::sarseq_apb_rsp_t  apbRsp,
   input  wire logic                         timerTrig,
   input  wire logic                         extTrig,
   input  wire logic                         compHigh,
   output      sarseq_pkg::sarseq_analog_t   analogCtl,
   output logic [15:0]                       pinDigital,
   output logic                              irq
);
   import sarseq_pkg::*;

   sarseq_state_vec_t s_q;
   sarseq_state_vec_t s_d;

   logic        wrEn;
   logic        rdEn;
   logic [15:0] rdWord;
   logic        trig;
   logic        convOn;
   logic [3:0]  smpi;
   logic [3:0]  slot;
   logic [9:0]  bitMask;
   logic [9:0]  trial;

   assign apbRsp     = s_q.rsp;
   assign analogCtl  = s_q.ana;
   assign pinDigital = s_q.pinDigital;
   assign irq        = s_q.irq;

   // ===========================================================================
   // Register bus and sequencer.
   always_comb begin
      s_d     = s_q;
      convOn  = s_q.ctrl1[SARSEQ_C1_ON];
      smpi    = s_q.ctrl2[SARSEQ_C2_SMPI +: 4];
      wrEn    = apbReq.psel && apbReq.penable && apbReq.pwrite && !s_q.rsp.pready;
      rdEn    = apbReq.psel && apbReq.penable && !apbReq.pwrite && !s_q.rsp.pready;
      rdWord  = 16'h0000;
      slot    = s_q.wrPtr;
      // Trials begin after two settling TADs, so bit 9 is tried at count 2; counts 0 and 1
      // wrap to a large shift and give an empty mask.
      bitMask = 10'h200 >> (s_q.bitCnt - 4'h2);
      trial   = s_q.sar | bitMask;
      trig    = 1'b0;

      // Completed access; pready stands for one cycle, so every access takes three PCLKs with the setup cycle.
      s_d.rsp.pready  = apbReq.psel && apbReq.penable && !s_q.rsp.pready;
      s_d.rsp.pslverr = 1'b0;

      case (apbReq.paddr)
         SARSEQ_OFF_CTRL1:  rdWord = s_q.ctrl1;
         SARSEQ_OFF_CTRL2:  rdWord = s_q.ctrl2;
         SARSEQ_OFF_CTRL3:  rdWord = s_q.ctrl3;
         SARSEQ_OFF_CHSEL:  rdWord = s_q.chsel;
         SARSEQ_OFF_PINCFG: rdWord = s_q.pincfg;
         SARSEQ_OFF_SCAN:   rdWord = s_q.scan;
         SARSEQ_OFF_STAT:   rdWord = {14'h0000, s_q.stat};
         SARSEQ_OFF_MASK:   rdWord = {14'h0000, s_q.mask};
         default: begin
            if (apbReq.paddr[7:6] == SARSEQ_OFF_BUF[7:6] && apbReq.paddr[1:0] == 2'b00) begin
               rdWord = {6'h00, s_q.buffer[apbReq.paddr[5:2]*10 +: 10]};
               s_d.rsp.pslverr = wrEn;
            end else if (rdEn || wrEn) begin
               s_d.rsp.pslverr = 1'b1;
            end
         end
      endcase
      s_d.rsp.prdata = rdEn ? {16'h0000, rdWord} : 32'h0000_0000;

      if (wrEn) begin
         case (apbReq.paddr)
            SARSEQ_OFF_CTRL1:  s_d.ctrl1  = apbReq.pwdata[15:0];
            SARSEQ_OFF_CTRL2:  s_d.ctrl2  = apbReq.pwdata[15:0];
            SARSEQ_OFF_CTRL3:  s_d.ctrl3  = apbReq.pwdata[15:0];
            SARSEQ_OFF_CHSEL:  s_d.chsel  = apbReq.pwdata[15:0];
            SARSEQ_OFF_PINCFG: s_d.pincfg = apbReq.pwdata[15:0];
            SARSEQ_OFF_SCAN:   s_d.scan   = apbReq.pwdata[15:0];
            SARSEQ_OFF_STAT:   s_d.stat   = s_q.stat & ~apbReq.pwdata[1:0];
            SARSEQ_OFF_MASK:   s_d.mask   = apbReq.pwdata[1:0];
            default: begin
               // Result words are read-only; writes there are refused with pslverr.
            end
         endcase
      end

      // Conversion clock: one TAD every (divider+1) half-cycles, rounded to whole clocks.
      s_d.tadTick = 1'b0;
      if (s_q.divCnt >= {1'b0, s_q.ctrl3[5:1]}) begin
         s_d.divCnt  = 6'h00;
         s_d.tadTick = 1'b1;
      end else begin
         s_d.divCnt = s_q.divCnt + 6'h01;
      end

      // Trigger selection; soft trigger is the falling edge of the sample-control bit.
      s_d.trigPrev = s_q.ctrl1[SARSEQ_C1_SAMPLE_CONTROL_BIT];
      case (s_q.ctrl1[SARSEQ_C1_SSRC +: 3])
         SARSEQ_TRG_SOFT:  trig = s_q.trigPrev && !s_q.ctrl1[SARSEQ_C1_SAMPLE_CONTROL_BIT];
         SARSEQ_TRG_EXT:   trig = extTrig;
         SARSEQ_TRG_TIMER: trig = timerTrig;
         SARSEQ_TRG_AUTO:  trig = s_q.tadTick && s_q.samCnt >= s_q.ctrl3[SARSEQ_C3_SAMC +: 5];
         default:          trig = 1'b0;
      endcase

      // Channel routing: one of sixteen inputs onto the CH0 hold, alternate set on every second pass.
      s_d.ana.chanSel = s_q.muxB ? s_q.chsel[11:8] : s_q.chsel[3:0];
      s_d.ana.refExt  = s_q.ctrl2[SARSEQ_C2_VREF];
      s_d.pinDigital  = s_q.pincfg;

      case (s_q.state)
         SARSEQ_IDLE: begin
            s_d.ana.sampleHold = 1'b0;
            s_d.ana.convBusy   = 1'b0;
            if (convOn && s_q.ctrl1[SARSEQ_C1_SAMPLE_CONTROL_BIT]) begin
               s_d.state          = SARSEQ_SAMPLE;
               s_d.samCnt         = 5'h00;
               s_d.ana.sampleHold = 1'b1;
            end
         end
         SARSEQ_SAMPLE: begin
            if (s_q.tadTick && s_q.samCnt != 5'h1f) begin
               s_d.samCnt = s_q.samCnt + 5'h01;
            end
            if (trig) begin
               s_d.state          = SARSEQ_CONV;
               s_d.ana.sampleHold = 1'b0;
               s_d.ana.convBusy   = 1'b1;
               s_d.bitCnt         = 4'h0;
               s_d.sar            = 10'h000;
               s_d.ctrl1[SARSEQ_C1_SAMPLE_CONTROL_BIT] = 1'b0;
            end
         end
         SARSEQ_CONV: begin
            // Two TADs of settling, then one bit per TAD over ten TADs.
            if (s_q.tadTick) begin
               s_d.bitCnt = s_q.bitCnt + 4'h1;
               if (s_q.bitCnt >= 4'h2 && s_q.bitCnt < SARSEQ_CONV_TAD) begin
                  s_d.sar = compHigh ? trial : s_q.sar;
               end
               if (s_q.bitCnt == SARSEQ_CONV_TAD - 4'h1) begin
                  if (s_q.ctrl2[SARSEQ_C2_BUFFER_SPLIT]) begin
                     slot = {s_q.half, s_q.wrPtr[2:0]};
                  end
                  s_d.buffer[slot*10 +: 10] = compHigh ? trial : s_q.sar;
                  s_d.wrPtr = s_q.wrPtr + 4'h1;
                  s_d.seqCnt = s_q.seqCnt + 4'h1;
                  s_d.muxB = s_q.ctrl2[SARSEQ_C2_ALTERNATE_INPUT_SELECT] && !s_q.muxB;
                  s_d.state = SARSEQ_IDLE;
                  s_d.ana.convBusy = 1'b0;
                  if (s_q.seqCnt == smpi) begin
                     s_d.seqCnt = 4'h0;
                     s_d.wrPtr  = 4'h0;
                     s_d.half   = s_q.ctrl2[SARSEQ_C2_BUFFER_SPLIT] && !s_q.half;
                     s_d.stat   = s_d.stat | 2'b11;
                     s_d.ctrl1[SARSEQ_C1_DONE] = 1'b1;
                  end
                  if (s_q.ctrl1[SARSEQ_C1_AUTO]) begin
                     s_d.ctrl1[SARSEQ_C1_SAMPLE_CONTROL_BIT] = 1'b1;
                  end
               end
            end
         end
         default: s_d.state = SARSEQ_IDLE;
      endcase
      // The front end is shown the trial of the coming tick, so its answer is settled when
      // that tick samples it, whatever the divider setting.
      s_d.ana.approxTrial = (s_d.state == SARSEQ_CONV) ?
                            (s_d.sar | (10'h200 >> (s_d.bitCnt - 4'h2))) : 10'h000;

      // Turning the converter off before the final TAD tick aborts the running conversion without a buffer write.
      if (!s_d.ctrl1[SARSEQ_C1_ON]) begin
         s_d.state          = SARSEQ_IDLE;
         s_d.ana.sampleHold = 1'b0;
         s_d.ana.convBusy   = 1'b0;
         s_d.seqCnt         = 4'h0;
         s_d.wrPtr          = 4'h0;
      end
      s_d.irq = |(s_d.stat & s_d.mask);
   end

   // ===========================================================================
   // State register. No sleep input: the block converts only on clk edges with clkEn high.
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q        <= '0;
         s_q.ctrl1  <= SARSEQ_RST_REG;
         s_q.pincfg <= SARSEQ_RST_PINCFG;
         s_q.state  <= SARSEQ_IDLE;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

endmodule

// file: sim/sarseq_analog_model.sv
// Behavioural analog front end: one held input level feeding the comparator.
// Assumes the bench sets level before each acquisition starts.
`timescale 1ns/10ps
module sarseq_analog_model (
   input  wire logic                       clk,
   input  wire sarseq_pkg::sarseq_analog_t analogCtl,
   input  wire logic [9:0]                 level,
   output logic                            compHigh
);
   import sarseq_pkg::*;
   logic [9:0] held;
   // =====================================================================
   // Hold and compare
   always_ff @(posedge clk) if (analogCtl.sampleHold) held <= level;
   // The input sits half a step above level, so a trial equal to it still reads high.
   assign compHigh = analogCtl.approxTrial <= held;
endmodule

// file: sim/sarseq_assertions.sv
// Port checker for the converter sequencer, bound to its top module.
// Assumes clkEn stays high and the conversion clock divider is left at zero.
`timescale 1ns/10ps
module sarseq_checker (
   input wire logic                        clk,
   input wire logic                        srst,
   input wire logic                        clkEn,
   input wire sarseq_pkg::sarseq_apb_req_t apbReq,
   input wire sarseq_pkg::sarseq_apb_rsp_t apbRsp,
   input wire sarseq_pkg::sarseq_analog_t  analogCtl,
   input wire logic [15:0]                 pinDigital,
   input wire logic                        irq
);
   import sarseq_pkg::*;
   logic [9:0] busyCnt_q;
   logic       wrAcc;
   // =====================================================================
   // Helpers and properties
   assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
   always_ff @(posedge clk)
      busyCnt_q <= (srst || !analogCtl.convBusy) ? 10'h000 : busyCnt_q + 10'h001;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_ready_answer;
      apbReq.psel && apbReq.penable && !apbRsp.pready && clkEn |=> apbRsp.pready;
   endproperty
   a_ready_answer: assert property (p_ready_answer) else $error("pready late");
   property p_ready_pulse;
      apbRsp.pready |=> !apbRsp.pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_err_ready;
      apbRsp.pslverr |-> apbRsp.pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
   property p_start;
      wrAcc && !apbRsp.pready && apbReq.paddr == SARSEQ_OFF_CTRL1 && apbReq.pwdata[15]
      && apbReq.pwdata[1] && !analogCtl.sampleHold && !analogCtl.convBusy
      |-> ##[1:3] analogCtl.sampleHold;
   endproperty
   a_start: assert property (p_start) else $error("no acquisition");
   property p_trig;
      $fell(analogCtl.sampleHold) |-> ##[0:2] analogCtl.convBusy;
   endproperty
   a_trig: assert property (p_trig) else $error("no conversion");
   property p_excl;
      !(analogCtl.sampleHold && analogCtl.convBusy);
   endproperty
   a_excl: assert property (p_excl) else $error("sample during conversion");
   property p_conv_len;
      $fell(analogCtl.convBusy) |-> busyCnt_q >= 10'd12 && busyCnt_q <= 10'd13;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length");
   property p_irq_hold;
      $fell(irq) |-> $past(wrAcc) || $past(wrAcc, 2) || $past(wrAcc, 3);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
   property p_pin_write;
      $changed(pinDigital) |-> $past(wrAcc) || $past(wrAcc, 2);
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("pin config moved");
endmodule
bind sarseq_top sarseq_checker i_chk (.clk(clk), .srst(srst), .clkEn(clkEn), .apbReq(apbReq),
   .apbRsp(apbRsp), .analogCtl(analogCtl), .pinDigital(pinDigital), .irq(irq));

// file: sim/sarseq_top_tb.sv
// Self-checking bench: APB register tasks and conversion sequences.
// Assumes the analog model in its own file and the checker bound to the top.
`timescale 1ns/10ps
module sarseq_top_tb;
   import sarseq_pkg::*;
   logic            clk, srst, clkEn, timerTrig, extTrig, compHigh, irq;
   sarseq_apb_req_t apbReq;
   sarseq_apb_rsp_t apbRsp;
   sarseq_analog_t  analogCtl;
   logic [15:0]     pinDigital;
   logic [9:0]      level;
   logic [31:0]     rdata;
   int              num_errors, checked;
   logic [2:0]      srcs [3] = '{SARSEQ_TRG_EXT, SARSEQ_TRG_TIMER, SARSEQ_TRG_AUTO};
   logic [9:0]      lvs [3] = '{10'h3ff, 10'h001, 10'h200};
   sarseq_top i_sarseq_top (.clk(clk), .srst(srst), .clkEn(clkEn), .apbReq(apbReq),
      .apbRsp(apbRsp), .timerTrig(timerTrig), .extTrig(extTrig), .compHigh(compHigh),
      .analogCtl(analogCtl), .pinDigital(pinDigital), .irq(irq));
   sarseq_analog_model i_sarseq_analog_model (.clk(clk), .analogCtl(analogCtl), .level(level),
      .compHigh(compHigh));
   // =====================================================================
   // Tasks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task acc(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic eErr);
      int n;
      @(posedge clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      chk({31'h0, apbRsp.pready}, 32'h1);
      rdata = apbRsp.prdata;
      chk({31'h0, apbRsp.pslverr}, {31'h0, eErr});
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0, 1'b0);
      chk(rdata, exp);
   endtask
   task chkIrq(input logic e);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   // Only waits for busy edges, so a conversion that never starts still passes once the first wait runs out at 50 cycles.
   task conv(input logic [2:0] src, input logic [9:0] lvl);
      int n;
      level <= lvl;
      acc(1'b1, SARSEQ_OFF_CTRL1, {16'h0, 16'h8002 | {8'h00, src, 5'h00}}, 1'b0);
      repeat (3) @(posedge clk);
      if (src == SARSEQ_TRG_SOFT)
         acc(1'b1, SARSEQ_OFF_CTRL1, 32'h8000, 1'b0);
      else if (src != SARSEQ_TRG_AUTO) begin
         timerTrig <= (src == SARSEQ_TRG_TIMER);
         extTrig <= (src == SARSEQ_TRG_EXT);
         @(posedge clk);
         timerTrig <= 1'b0;
         extTrig <= 1'b0;
      end
      n = 0;
      while (analogCtl.convBusy !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      while (analogCtl.convBusy !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 100), 32'h1);
   endtask
   // =====================================================================
   // Sequence
   initial begin
      {srst, clkEn, timerTrig, extTrig, level, apbReq} <= {1'b1, 1'b1, 2'b00, 10'h0, 43'h0};
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
      acc(1'b1, SARSEQ_OFF_PINCFG, 32'ha5c3, 1'b0);
      rd(SARSEQ_OFF_PINCFG, 32'ha5c3);
      chk({16'h0, pinDigital}, 32'ha5c3);
      acc(1'b1, SARSEQ_OFF_CHSEL, 32'h0b06, 1'b0);
      acc(1'b1, SARSEQ_OFF_CTRL2, 32'h2000, 1'b0);
      repeat (2) @(posedge clk);
      chk({27'h0, analogCtl.chanSel, analogCtl.refExt}, 32'hd);
      acc(1'b1, 8'h20, 32'h1, 1'b1);
      acc(1'b1, SARSEQ_OFF_CTRL3, 32'h0100, 1'b0);
      acc(1'b1, SARSEQ_OFF_CTRL2, 32'h0004, 1'b0);
      acc(1'b1, SARSEQ_OFF_MASK, 32'h1, 1'b0);
      conv(SARSEQ_TRG_SOFT, 10'h2a5);
      rd(SARSEQ_OFF_STAT, 32'h0);
      chkIrq(1'b0);
      conv(SARSEQ_TRG_SOFT, 10'h13c);
      rd(SARSEQ_OFF_STAT, 32'h3);
      rd(SARSEQ_OFF_CTRL1, 32'h8001);
      chkIrq(1'b1);
      rd(SARSEQ_OFF_BUF, 32'h2a5);
      rd(SARSEQ_OFF_BUF + 8'h04, 32'h13c);
      acc(1'b1, SARSEQ_OFF_BUF, 32'h0, 1'b1);
      rd(SARSEQ_OFF_BUF, 32'h2a5);
      rd(SARSEQ_OFF_STAT, 32'h3);
      acc(1'b1, SARSEQ_OFF_MASK, 32'h0, 1'b0);
      chkIrq(1'b0);
      acc(1'b1, SARSEQ_OFF_MASK, 32'h1, 1'b0);
      chkIrq(1'b1);
      acc(1'b1, SARSEQ_OFF_STAT, 32'h3, 1'b0);
      rd(SARSEQ_OFF_STAT, 32'h0);
      chkIrq(1'b0);
      acc(1'b1, SARSEQ_OFF_CTRL1, 32'h0, 1'b0);
      acc(1'b1, SARSEQ_OFF_CTRL2, 32'h0, 1'b0);
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, SARSEQ_OFF_CTRL1, {24'h0, srcs[i], 5'h00}, 1'b0);
         conv(srcs[i], lvs[i]);
         rd(SARSEQ_OFF_BUF, {22'h0, lvs[i]});
         acc(1'b1, SARSEQ_OFF_CTRL1, 32'h0, 1'b0);
      end
      acc(1'b1, SARSEQ_OFF_CTRL2, 32'h0003, 1'b0);
      conv(SARSEQ_TRG_SOFT, 10'h155);
      repeat (2) @(posedge clk);
      chk({28'h0, analogCtl.chanSel}, 32'hb);
      conv(SARSEQ_TRG_SOFT, 10'h0aa);
      rd(SARSEQ_OFF_BUF, 32'h155);
      rd(SARSEQ_OFF_BUF + 8'h20, 32'h0aa);
      close_out;
   end
   initial begin
      #200000;
      num_errors++;
      close_out;
   end
endmodule
